// ### inc/stp_pkg.sv
// Shared constants and types for the spanning tree port state control.
// Assumes one 100 MHz system clock; all protocol times count in seconds.
package stp_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int          CLK_HZ             = 100_000_000;
   localparam int          TICK_PERIOD_S      = 1;
   localparam int          TICK_CYCLES_DFLT   = CLK_HZ * TICK_PERIOD_S;
   localparam int          SEC_W              = 8;
   localparam logic [7:0]  HELLO_S_RST        = 8'h02;
   localparam logic [7:0]  MAX_AGE_S_RST      = 8'h14;
   localparam logic [7:0]  FWD_DELAY_S_RST    = 8'h0f;

   // ****************************************************************
   // Identifiers and costs
   // ****************************************************************
   localparam int          PRIO_W             = 16;
   localparam int          MAC_W              = 48;
   localparam int          BID_W              = PRIO_W + MAC_W;
   localparam int          PID_W              = 32;
   localparam int          COST_W             = 16;
   localparam int          RCOST_W            = 32;
   localparam logic [15:0] BRIDGE_PRIO_RST    = 16'h8000;
   localparam logic [15:0] PORT_PRIO_RST      = 16'h8000;
   localparam logic [15:0] COST_100M          = 16'h0013;
   localparam logic [15:0] COST_1000M         = 16'h0004;

   // ****************************************************************
   // Port states
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_BLOCKING,
      ST_LISTENING,
      ST_LEARNING,
      ST_FORWARDING,
      ST_DISABLED
   } port_state_e;

   localparam port_state_e PORT_STATE_RST     = ST_BLOCKING;

endpackage

// ### rtl/stp_port_fsm.sv
// Per-port state machine: steps one port through the five port states.
// Assumes a one-cycle seconds tick and a forwarding role from the election.
`timescale 1ns/1ps
module stp_port_fsm
   import stp_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             resetn_in,
   // Control
   input  wire logic             port_en_in,
   input  wire logic             fwd_role_in,
   input  wire logic             tick_in,
   input  wire logic [SEC_W-1:0] fwd_delay_in,
   // Status
   output port_state_e           state_out,
   output logic                  fwd_en_out,
   output logic                  learn_en_out
);

   typedef struct packed {
      port_state_e      state;
      logic [SEC_W-1:0] timer;
      logic             fwd;
      logic             learn;
   } fsm_s;

   fsm_s s_r;
   fsm_s s_nxt;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_nxt = s_r;
      if (tick_in && s_r.timer != '0) begin
         s_nxt.timer = s_r.timer - 1'b1;
      end
      unique case (s_r.state)
         ST_BLOCKING: begin
            if (!port_en_in) begin
               s_nxt.state = ST_DISABLED;
            end else if (fwd_role_in) begin
               s_nxt.state = ST_LISTENING;
               s_nxt.timer = fwd_delay_in;
            end
         end
         ST_LISTENING: begin
            if (!port_en_in || !fwd_role_in) begin
               s_nxt.state = ST_DISABLED;
            end else if (s_r.timer == '0) begin
               s_nxt.state = ST_LEARNING;
               s_nxt.timer = fwd_delay_in;
            end
         end
         ST_LEARNING: begin
            if (!port_en_in || !fwd_role_in) begin
               s_nxt.state = ST_DISABLED;
            end else if (s_r.timer == '0) begin
               s_nxt.state = ST_FORWARDING;
            end
         end
         ST_FORWARDING: begin
            if (!port_en_in || !fwd_role_in) begin
               s_nxt.state = ST_DISABLED;
            end
         end
         ST_DISABLED: begin
            if (port_en_in) begin
               s_nxt.state = ST_BLOCKING;
            end
         end
         default: begin
            s_nxt.state = ST_DISABLED;
         end
      endcase
      s_nxt.fwd   = (s_nxt.state == ST_FORWARDING);
      s_nxt.learn = (s_nxt.state == ST_LEARNING) || (s_nxt.state == ST_FORWARDING);
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_r.state <= PORT_STATE_RST;
         s_r.timer <= '0;
         s_r.fwd   <= 1'b0;
         s_r.learn <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign state_out    = s_r.state;
   assign fwd_en_out   = s_r.fwd;
   assign learn_en_out = s_r.learn;

endmodule

// ### rtl/stp_ctrl.sv
// Spanning tree control: root election, port roles, timers, BPDU exchange.
// Assumes BPDU frames are decoded/encoded outside; fields arrive as words.
`timescale 1ns/1ps
module stp_ctrl
   import stp_pkg::*;
#(
   parameter int NUM_PORTS   = 10,
   parameter int TICK_CYCLES = TICK_CYCLES_DFLT
)
(
   // Clock and reset
   input  wire logic                                clk_in,
   input  wire logic                                resetn_in,
   // Global configuration
   input  wire logic                                stp_en_in,
   input  wire logic [MAC_W-1:0]                    station_mac_in,
   input  wire logic                                bridge_prio_we_in,
   input  wire logic [PRIO_W-1:0]                   bridge_prio_in,
   input  wire logic                                timers_we_in,
   input  wire logic [SEC_W-1:0]                    hello_s_in,
   input  wire logic [SEC_W-1:0]                    max_age_s_in,
   input  wire logic [SEC_W-1:0]                    fwd_delay_s_in,
   // Per-port configuration
   input  wire logic [NUM_PORTS-1:0]                port_en_in,
   input  wire logic [NUM_PORTS-1:0]                port_gig_in,
   input  wire logic [NUM_PORTS-1:0]                port_prio_we_in,
   input  wire logic [PRIO_W-1:0]                   port_prio_in,
   input  wire logic [NUM_PORTS-1:0]                port_cost_we_in,
   input  wire logic [COST_W-1:0]                   port_cost_in,
   // Received BPDU
   input  wire logic                                rx_valid_in,
   input  wire logic [$clog2(NUM_PORTS)-1:0]        rx_port_in,
   input  wire logic [BID_W-1:0]                    rx_root_id_in,
   input  wire logic [RCOST_W-1:0]                  rx_cost_in,
   input  wire logic [BID_W-1:0]                    rx_bridge_id_in,
   input  wire logic [PID_W-1:0]                    rx_port_id_in,
   // Transmitted BPDU
   output logic                                     tx_valid_out,
   output logic [$clog2(NUM_PORTS)-1:0]             tx_port_out,
   output logic [BID_W-1:0]                         tx_root_id_out,
   output logic [RCOST_W-1:0]                       tx_cost_out,
   output logic [BID_W-1:0]                         tx_bridge_id_out,
   output logic [PID_W-1:0]                         tx_port_id_out,
   // Port status and frame gating
   output logic [NUM_PORTS-1:0][2:0]                port_state_out,
   output logic [NUM_PORTS-1:0]                     fwd_en_out,
   output logic [NUM_PORTS-1:0]                     learn_en_out,
   // Bridge status
   output logic                                     is_root_out,
   output logic [BID_W-1:0]                         root_id_out,
   output logic [RCOST_W-1:0]                       root_cost_out,
   output logic [$clog2(NUM_PORTS)-1:0]             root_port_out
);

   localparam int PW = $clog2(NUM_PORTS);

   if (NUM_PORTS < 2 || NUM_PORTS > 256 || TICK_CYCLES < 2) begin : g_bad_cfg
      $error("stp_ctrl: unsupported NUM_PORTS or TICK_CYCLES");
   end

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [31:0]                            tick_cnt;
      logic                                   tick;
      logic [SEC_W-1:0]                       hello_cnt;
      logic [PRIO_W-1:0]                      bridge_prio;
      logic [SEC_W-1:0]                       hello_s;
      logic [SEC_W-1:0]                       max_age_s;
      logic [SEC_W-1:0]                       fwd_delay_s;
      logic [NUM_PORTS-1:0][PRIO_W-1:0]       port_prio;
      logic [NUM_PORTS-1:0][COST_W-1:0]       port_cost;
      logic [NUM_PORTS-1:0]                   cost_set;
      logic [NUM_PORTS-1:0]                   info_v;
      logic [NUM_PORTS-1:0][BID_W-1:0]        info_root;
      logic [NUM_PORTS-1:0][RCOST_W-1:0]      info_cost;
      logic [NUM_PORTS-1:0][BID_W-1:0]        info_br;
      logic [NUM_PORTS-1:0][PID_W-1:0]        info_pid;
      logic [NUM_PORTS-1:0][SEC_W-1:0]        age;
      logic                                   is_root;
      logic [BID_W-1:0]                       root_id;
      logic [RCOST_W-1:0]                     root_cost;
      logic [PW-1:0]                          root_port;
      logic [NUM_PORTS-1:0]                   desig;
      logic [NUM_PORTS-1:0]                   role;
      logic [NUM_PORTS-1:0]                   tx_pend;
      logic                                   tx_valid;
      logic [PW-1:0]                          tx_port;
      logic [BID_W-1:0]                       tx_root;
      logic [RCOST_W-1:0]                     tx_cost;
      logic [BID_W-1:0]                       tx_br;
      logic [PID_W-1:0]                       tx_pid;
   } ctrl_s;

   ctrl_s         s_r;
   ctrl_s         s_nxt;
   port_state_e   st [NUM_PORTS];
   logic [31:0]   tick_last;

   assign tick_last = 32'(TICK_CYCLES - 1);

   // ****************************************************************
   // Election, timers and BPDU exchange
   // ****************************************************************
   always_comb begin
      logic [BID_W-1:0]                   own_id;
      logic [BID_W+RCOST_W+BID_W+PID_W-1:0] best;
      logic [BID_W+RCOST_W+BID_W+PID_W-1:0] cand;
      logic [RCOST_W-1:0]                 path;
      logic [PW-1:0]                      best_port;
      logic                               found;
      logic [NUM_PORTS-1:0]               role;
      logic [NUM_PORTS-1:0]               desig;
      logic                               send;
      logic                               sent;
      logic [RCOST_W-1:0]                 rcost;
      own_id    = '0;
      best      = '0;
      cand      = '0;
      path      = '0;
      best_port = '0;
      found     = 1'b0;
      role      = '0;
      desig     = '0;
      send      = 1'b0;
      sent      = 1'b0;
      rcost     = '0;
      s_nxt          = s_r;
      s_nxt.tick     = 1'b0;
      s_nxt.tx_valid = 1'b0;

      if (s_r.tick_cnt == tick_last) begin
         s_nxt.tick_cnt = '0;
         s_nxt.tick     = 1'b1;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + 32'h0000_0001;
      end

      if (bridge_prio_we_in) begin
         s_nxt.bridge_prio = bridge_prio_in;
      end
      // Hello within max age is software's duty
      if (timers_we_in) begin
         s_nxt.hello_s     = hello_s_in;
         s_nxt.max_age_s   = max_age_s_in;
         s_nxt.fwd_delay_s = fwd_delay_s_in;
      end

      own_id = {s_r.bridge_prio, station_mac_in};

      for (int i = 0; i < NUM_PORTS; i++) begin
         if (port_prio_we_in[i]) begin
            s_nxt.port_prio[i] = port_prio_in;
         end
         if (port_cost_we_in[i]) begin
            s_nxt.port_cost[i] = port_cost_in;
            s_nxt.cost_set[i]  = 1'b1;
         end else if (!s_r.cost_set[i]) begin
            s_nxt.port_cost[i] = port_gig_in[i] ? COST_1000M : COST_100M;
         end
         // Age stored info, drop when too old
         if (s_r.info_v[i] && s_r.tick) begin
            s_nxt.age[i] = s_r.age[i] + 1'b1;
         end
         if (!port_en_in[i] || (s_r.info_v[i] && s_r.age[i] > s_r.max_age_s)) begin
            s_nxt.info_v[i] = 1'b0;
         end
      end

      if (rx_valid_in && port_en_in[rx_port_in]) begin
         s_nxt.info_v[rx_port_in]    = 1'b1;
         s_nxt.info_root[rx_port_in] = rx_root_id_in;
         s_nxt.info_cost[rx_port_in] = rx_cost_in;
         s_nxt.info_br[rx_port_in]   = rx_bridge_id_in;
         s_nxt.info_pid[rx_port_in]  = rx_port_id_in;
         s_nxt.age[rx_port_in]       = '0;
      end

      // Best path to root picks root port
      best = {own_id, {RCOST_W{1'b0}}, {BID_W{1'b1}}, {PID_W{1'b1}}};
      for (int i = 0; i < NUM_PORTS; i++) begin
         path = s_r.info_cost[i] + RCOST_W'(s_r.port_cost[i]);
         cand = {s_r.info_root[i], path, s_r.info_br[i], s_r.info_pid[i]};
         if (s_r.info_v[i] && port_en_in[i] && cand < best) begin
            best      = cand;
            best_port = PW'(i);
            found     = 1'b1;
         end
      end
      rcost = found ? best[BID_W+PID_W +: RCOST_W] : '0;

      // Designated where our offer beats the segment's
      for (int i = 0; i < NUM_PORTS; i++) begin
         cand = {best[BID_W+RCOST_W+BID_W+PID_W-1 -: BID_W], rcost, own_id,
                 s_r.port_prio[i], PRIO_W'(i)};
         desig[i] = port_en_in[i] && !(found && best_port == PW'(i)) &&
                    (!s_r.info_v[i] ||
                     cand < {s_r.info_root[i], s_r.info_cost[i], s_r.info_br[i], s_r.info_pid[i]});
         // Role follows election, blocked links return
         role[i] = port_en_in[i] &&
                   (!stp_en_in || desig[i] || (found && best_port == PW'(i)));
      end

      s_nxt.is_root   = !found;
      s_nxt.root_id   = best[BID_W+RCOST_W+BID_W+PID_W-1 -: BID_W];
      s_nxt.root_cost = rcost;
      s_nxt.root_port = best_port;
      s_nxt.desig     = desig;
      s_nxt.role      = role;

      if (role != s_r.role || s_nxt.root_id != s_r.root_id) begin
         send = 1'b1;
      end
      if (s_r.is_root && s_r.tick) begin
         if (s_r.hello_cnt + 1'b1 >= s_r.hello_s) begin
            s_nxt.hello_cnt = '0;
            send            = 1'b1;
         end else begin
            s_nxt.hello_cnt = s_r.hello_cnt + 1'b1;
         end
      end
      // Root port info regenerates own BPDUs
      if (!s_r.is_root && rx_valid_in && rx_port_in == s_r.root_port) begin
         send = 1'b1;
      end

      for (int i = 0; i < NUM_PORTS; i++) begin
         if (!sent && s_r.tx_pend[i]) begin
            sent              = 1'b1;
            s_nxt.tx_valid    = stp_en_in && s_r.desig[i];
            s_nxt.tx_port     = PW'(i);
            s_nxt.tx_root     = s_r.root_id;
            s_nxt.tx_cost     = s_r.root_cost;
            s_nxt.tx_br       = own_id;
            s_nxt.tx_pid      = {s_r.port_prio[i], PRIO_W'(i)};
            s_nxt.tx_pend[i]  = 1'b0;
         end
      end
      // New requests win over the clear
      if (send) begin
         s_nxt.tx_pend = s_nxt.tx_pend | s_r.desig;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_r             <= '0;
         s_r.bridge_prio <= BRIDGE_PRIO_RST;
         s_r.hello_s     <= HELLO_S_RST;
         s_r.max_age_s   <= MAX_AGE_S_RST;
         s_r.fwd_delay_s <= FWD_DELAY_S_RST;
         s_r.port_prio   <= {NUM_PORTS{PORT_PRIO_RST}};
         s_r.port_cost   <= {NUM_PORTS{COST_100M}};
         s_r.is_root     <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************************************
   // Port state machines
   // ****************************************************************
   for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
      stp_port_fsm u_fsm (
         .clk_in       (clk_in),
         .resetn_in    (resetn_in),
         .port_en_in   (port_en_in[g]),
         .fwd_role_in  (s_r.role[g]),
         .tick_in      (s_r.tick),
         .fwd_delay_in (s_r.fwd_delay_s),
         .state_out    (st[g]),
         .fwd_en_out   (fwd_en_out[g]),
         .learn_en_out (learn_en_out[g])
      );
      // State visible for data path gating
      assign port_state_out[g] = st[g];
   end

   assign tx_valid_out     = s_r.tx_valid;
   assign tx_port_out      = s_r.tx_port;
   assign tx_root_id_out   = s_r.tx_root;
   assign tx_cost_out      = s_r.tx_cost;
   assign tx_bridge_id_out = s_r.tx_br;
   assign tx_port_id_out   = s_r.tx_pid;
   assign is_root_out      = s_r.is_root;
   assign root_id_out      = s_r.root_id;
   assign root_cost_out    = s_r.root_cost;
   assign root_port_out    = s_r.root_port;

endmodule

// ### tb/stp_ctrl_chk.sv
// Checker bound to stp_ctrl: state moves, frame gating, timers, election.
// Assumes one clock domain and sees only the ports of stp_ctrl.
`timescale 1ns/1ps
module stp_ctrl_chk
   import stp_pkg::*;
#(
   parameter int NUM_PORTS   = 10,
   parameter int TICK_CYCLES = TICK_CYCLES_DFLT
)
(
   // Clock, reset and configuration
   input wire logic                         clk_in,
   input wire logic                         resetn_in,
   input wire logic                         stp_en_in,
   input wire logic [MAC_W-1:0]             station_mac_in,
   input wire logic                         bridge_prio_we_in,
   input wire logic [PRIO_W-1:0]            bridge_prio_in,
   input wire logic                         timers_we_in,
   input wire logic [SEC_W-1:0]             hello_s_in,
   input wire logic [SEC_W-1:0]             fwd_delay_s_in,
   input wire logic [NUM_PORTS-1:0]         port_en_in,
   // Watched outputs
   input wire logic                         tx_valid_out,
   input wire logic [$clog2(NUM_PORTS)-1:0] tx_port_out,
   input wire logic [BID_W-1:0]             tx_bridge_id_out,
   input wire logic [PID_W-1:0]             tx_port_id_out,
   input wire logic [NUM_PORTS-1:0][2:0]    port_state_out,
   input wire logic [NUM_PORTS-1:0]         fwd_en_out,
   input wire logic [NUM_PORTS-1:0]         learn_en_out,
   input wire logic                         is_root_out,
   input wire logic [BID_W-1:0]             root_id_out
);
   logic [PRIO_W-1:0] bprio_r;
   logic [SEC_W-1:0]  hello_r;
   logic [SEC_W-1:0]  fwd_r;
   int                dw_r;
   int                gap_r;

   // Mirrors of the loaded configuration, listening dwell and hello gap counters
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bprio_r <= BRIDGE_PRIO_RST;
         hello_r <= HELLO_S_RST;
         fwd_r   <= FWD_DELAY_S_RST;
         dw_r    <= 0;
         gap_r   <= 0;
      end else begin
         if (bridge_prio_we_in) begin
            bprio_r <= bridge_prio_in;
         end
         if (timers_we_in) begin
            hello_r <= hello_s_in;
            fwd_r   <= fwd_delay_s_in;
         end
         dw_r  <= (port_state_out[0] == 3'h1) ? dw_r + 1 : 0;
         gap_r <= (is_root_out && stp_en_in && port_en_in[0] && !tx_valid_out) ? gap_r + 1 : 0;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   sequence s_listen_done;
      port_state_out[0] == 3'h1 ##1 port_state_out[0] == 3'h2;
   endsequence

   for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      AST_STATE_RANGE: assert property (port_state_out[i] <= 3'h4)
         else $error("port state outside the five states");
      AST_FWD_GATE: assert property (fwd_en_out[i] == (port_state_out[i] == 3'h3))
         else $error("forward enable not tied to forwarding state");
      AST_LEARN_GATE: assert property (learn_en_out[i] == (port_state_out[i] inside {3'h2, 3'h3}))
         else $error("learn enable not tied to learning or forwarding");
      AST_MOVES: assert property ($changed(port_state_out[i]) |->
         {$past(port_state_out[i]), port_state_out[i]} inside {6'h01, 6'h04, 6'h0a, 6'h0c, 6'h13, 6'h14, 6'h1c, 6'h20})
         else $error("illegal port state move");
      AST_DIS_EXIT: assert property (port_state_out[i] == 3'h4 && port_en_in[i] |=> port_state_out[i] == 3'h0)
         else $error("disabled port did not return to blocking");
   end

   AST_RST_BLOCK: assert property (disable iff (1'b0) !resetn_in |-> port_state_out == '0 && fwd_en_out == '0)
      else $error("ports not blocking in reset");
   AST_DWELL_MIN: assert property (s_listen_done |-> dw_r + 2 >= (int'(fwd_r) - 1) * TICK_CYCLES)
      else $error("listening left too early");
   AST_DWELL_MAX: assert property (port_state_out[0] == 3'h1 |-> dw_r <= int'(fwd_r) * TICK_CYCLES + 4)
      else $error("listening held too long");
   AST_HELLO: assert property (gap_r <= (int'(hello_r) + 1) * TICK_CYCLES + NUM_PORTS + 4)
      else $error("root bridge missed its hello");
   AST_TX_FIELDS: assert property (tx_valid_out && $stable(bprio_r) |->
      tx_port_id_out[15:0] == 16'(tx_port_out) && tx_bridge_id_out == {bprio_r, station_mac_in})
      else $error("transmitted identifiers wrong");
   AST_ROOT: assert property ($past(resetn_in) && $stable(bprio_r) |-> root_id_out <= {bprio_r, station_mac_in} &&
      is_root_out == (root_id_out == {bprio_r, station_mac_in}))
      else $error("root election result wrong");
endmodule

bind stp_ctrl stp_ctrl_chk #(.NUM_PORTS(NUM_PORTS), .TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ### tb/stp_peer.sv
// Peer bridge model: hands decoded BPDUs to the receive side of stp_ctrl.
// Assumes the bench calls send; fields are scrambled between BPDUs.
`timescale 1ns/1ps
module stp_peer
   import stp_pkg::*;
(
   // Clock
   input  wire logic          clk_in,
   // Decoded BPDU
   output logic               rx_valid_out,
   output logic [1:0]         rx_port_out,
   output logic [BID_W-1:0]   rx_root_id_out,
   output logic [RCOST_W-1:0] rx_cost_out,
   output logic [BID_W-1:0]   rx_bridge_id_out,
   output logic [PID_W-1:0]   rx_port_id_out
);
   initial begin
      rx_valid_out = 1'b0;
      {rx_port_out, rx_root_id_out, rx_cost_out, rx_bridge_id_out, rx_port_id_out} = '0;
   end

   task automatic send(input logic [1:0] p, input logic [BID_W-1:0] r, input logic [RCOST_W-1:0] c,
                       input logic [BID_W-1:0] b, input logic [PID_W-1:0] i);
      @(negedge clk_in);
      rx_valid_out = 1'b1;
      {rx_port_out, rx_root_id_out, rx_cost_out, rx_bridge_id_out, rx_port_id_out} = {p, r, c, b, i};
      @(negedge clk_in);
      rx_valid_out = 1'b0;
      {rx_port_out, rx_root_id_out, rx_cost_out, rx_bridge_id_out, rx_port_id_out} = ~{p, r, c, b, i};
   endtask
endmodule

// ### tb/tb_spanning_tree_port_state_control.sv
// Self-checking bench for stp_ctrl: port walk, hello, election, ageing.
// Assumes stp_peer feeds BPDUs and stp_ctrl_chk is bound to the design.
`timescale 1ns/1ps
module tb_spanning_tree_port_state_control
   import stp_pkg::*;
;
   localparam int NP = 4;
   localparam int TK = 20;
   typedef struct packed {logic [1:0] p; logic [BID_W-1:0] r; logic [RCOST_W-1:0] c; logic [PID_W-1:0] i;} note_s;
   note_s                q[$];
   int                   n_mismatch = 0;
   int                   n_tests = 0;
   logic                 clk_in, resetn_in, stp_en_in, bridge_prio_we_in, timers_we_in;
   logic                 rx_valid_in, tx_valid_out, is_root_out;
   logic [MAC_W-1:0]     station_mac_in;
   logic [PRIO_W-1:0]    bridge_prio_in, port_prio_in;
   logic [SEC_W-1:0]     hello_s_in, max_age_s_in, fwd_delay_s_in;
   logic [NP-1:0]        port_en_in, port_gig_in, port_prio_we_in, port_cost_we_in, fwd_en_out, learn_en_out;
   logic [COST_W-1:0]    port_cost_in;
   logic [1:0]           rx_port_in, tx_port_out, root_port_out;
   logic [BID_W-1:0]     rx_root_id_in, rx_bridge_id_in, tx_root_id_out, tx_bridge_id_out, root_id_out;
   logic [RCOST_W-1:0]   rx_cost_in, tx_cost_out, root_cost_out;
   logic [PID_W-1:0]     rx_port_id_in, tx_port_id_out;
   logic [NP-1:0][2:0]   port_state_out;

   stp_ctrl #(.NUM_PORTS(NP), .TICK_CYCLES(TK)) u_dut (.*);
   stp_peer u_peer (.clk_in(clk_in), .rx_valid_out(rx_valid_in), .rx_port_out(rx_port_in),
      .rx_root_id_out(rx_root_id_in), .rx_cost_out(rx_cost_in), .rx_bridge_id_out(rx_bridge_id_in),
      .rx_port_id_out(rx_port_id_in));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic chk(input string nm, input logic [131:0] ex, input logic [131:0] got);
      n_tests++;
      if (got !== ex) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic end_sim();
      $display("Counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Waits on a port state, the root flag, or a BPDU sent on port 3
   task automatic wait_for(input int w, input logic [2:0] s, input int lim, output int cyc);
      cyc = 0;
      while (w < NP ? port_state_out[w] !== s : w == NP ? is_root_out !== s[0] :
             !(tx_valid_out === 1'b1 && tx_port_out === 2'h3)) begin
         @(negedge clk_in);
         cyc++;
         if (cyc > lim) begin
            n_mismatch++;
            $display("Error wait %0d expected %0h seen timeout", w, s);
            end_sim();
         end
      end
   endtask

   always @(posedge clk_in) begin
      #1;
      if (tx_valid_out === 1'b1 && q.size() > 0) begin
         chk("tx_bpdu", q.pop_front(), {tx_port_out, tx_root_id_out, tx_cost_out, tx_port_id_out});
      end
   end

   initial begin
      int c;
      logic [BID_W-1:0] pr;
      void'($urandom(32'h15477a34));
      resetn_in = 1'b0;
      {stp_en_in, bridge_prio_we_in, timers_we_in, port_prio_we_in, port_cost_we_in} = 11'h400;
      {bridge_prio_in, port_prio_in, port_cost_in} = '0;
      {hello_s_in, max_age_s_in, fwd_delay_s_in} = {8'h02, 8'h06, 8'h04};
      port_en_in = 4'hf;
      port_gig_in = 4'h2;
      station_mac_in = {16'h8abc, $urandom()};
      pr = {BRIDGE_PRIO_RST, 16'h0123, $urandom()};
      repeat (8) @(negedge clk_in);
      chk("reset", 0, {port_state_out, fwd_en_out, learn_en_out, tx_valid_out});
      resetn_in = 1'b1;
      repeat (2) @(negedge clk_in);
      chk("own_root", {1'b1, BRIDGE_PRIO_RST, station_mac_in}, {is_root_out, root_id_out});
      $display("test reset done");
      for (int s = 1; s <= 3; s++) begin
         wait_for(0, 3'(s), 400, c);
         chk("gate", {s == 3, s >= 2}, {fwd_en_out[0], learn_en_out[0]});
         if (s > 1) begin
            chk("dwell", 1, c >= 14 * TK - 1 && c <= 15 * TK + 2);
         end
      end
      {port_prio_in, port_prio_we_in} = {16'h1000, 4'h8};
      @(negedge clk_in);
      port_prio_we_in = 4'h0;
      wait_for(NP + 1, 0, 200, c);
      for (int p = 0; p < NP; p++) begin
         q.push_back({2'(p), BRIDGE_PRIO_RST, station_mac_in, 32'h0, (p == 3) ? 32'h1000_0003 : {PORT_PRIO_RST, 16'(p)}});
      end
      repeat (80) @(negedge clk_in);
      chk("tx_left", 0, q.size());
      $display("test walk and hello done");
      wait_for(NP + 1, 0, 200, c);
      u_peer.send(2'h2, pr, 32'h0, pr, 32'h8000_0001);
      u_peer.send(2'h1, pr, 32'ha, pr + 1, 32'h8000_0002);
      repeat (20) @(negedge clk_in);
      chk("elect", {1'b0, pr, 32'he, 2'h1}, {is_root_out, root_id_out, root_cost_out, root_port_out});
      q.push_back({2'h0, pr, 32'he, 32'h8000_0000});
      q.push_back({2'h3, pr, 32'he, 32'h1000_0003});
      u_peer.send(2'h1, pr, 32'ha, pr + 1, 32'h8000_0002);
      repeat (20) @(negedge clk_in);
      chk("tx_left", 0, q.size());
      {port_cost_in, port_cost_we_in} = {16'h0001, 4'h4};
      @(negedge clk_in);
      port_cost_we_in = 4'h0;
      repeat (5) @(negedge clk_in);
      chk("cost", {32'h1, 2'h2}, {root_cost_out, root_port_out});
      port_en_in = 4'hb;
      repeat (5) @(negedge clk_in);
      chk("failover", {3'h4, 32'he, 2'h1}, {port_state_out[2], root_cost_out, root_port_out});
      port_en_in = 4'hf;
      $display("test election and failover done");
      wait_for(NP, 3'h1, 600, c);
      chk("max_age", 1, c >= 20 * TK - 40 && c <= 21 * TK - 20);
      u_peer.send(2'h1, pr, 32'ha, pr + 1, 32'h8000_0002);
      repeat (4) @(negedge clk_in);
      chk("not_root", 0, is_root_out);
      {timers_we_in, bridge_prio_we_in, bridge_prio_in} = {2'b11, 16'h0000};
      @(negedge clk_in);
      {timers_we_in, bridge_prio_we_in} = 2'b00;
      repeat (3) @(negedge clk_in);
      chk("prio", {1'b1, 16'h0000, station_mac_in}, {is_root_out, root_id_out});
      $display("test priority done");
      repeat (100) @(negedge clk_in);
      end_sim();
   end
endmodule
